// File: verilog/abd_pkg.sv
// Shared types and constants for the ALU and branch datapath
`default_nettype none
package abd_pkg;
   // --------------------------------------------------------------
   // Operation codes presented by the decoder
   // --------------------------------------------------------------
   typedef enum logic [4:0] {
      ABD_NOP, ABD_ADD, ABD_ADC, ABD_WADD, ABD_SUB, ABD_SUB_BORROW, ABD_WSUB,
      ABD_AND, ABD_OR, ABD_XOR, ABD_COM, ABD_TWOS_CPL, ABD_SET_BITS, ABD_CLEAR_BITS,
      ABD_INC, ABD_DEC, ABD_ZS_TEST, ABD_ZERO_REG, ABD_ONES_REG, ABD_REL_JUMP, ABD_PTR_JUMP,
      ABD_REL_CALL, ABD_PTR_CALL, ABD_SUB_EXIT, ABD_INT_EXIT, ABD_CMP_SKIP, ABD_CMP,
      ABD_CMP_BORROW
   } abd_op_t;

   // Status flag positions
   localparam int ABD_FC = 0;
   localparam int ABD_FZ = 1;
   localparam int ABD_FN = 2;
   localparam int ABD_FV = 3;
   localparam int ABD_FS = 4;
   localparam int ABD_FH = 5;
   localparam int ABD_FI = 7;

   localparam logic [7:0] ABD_ALL_ONES = 8'hFF;
   localparam logic [7:0] ABD_ZERO8 = 8'h00;
   localparam logic [15:0] ABD_PC_RESET = 16'h0000;
   localparam logic [7:0] ABD_SREG_RESET = 8'h00;
   localparam logic [15:0] ABD_ONE16 = 16'h0001;
   localparam logic [15:0] ABD_SKIP1 = 16'h0002;
   localparam logic [15:0] ABD_SKIP2 = 16'h0003;

   // Cycle counts, minus one, for multi-cycle operations
   localparam logic [1:0] ABD_CYC_WORD = 2'h1;
   localparam logic [1:0] ABD_CYC_JMP = 2'h1;
   localparam logic [1:0] ABD_CYC_CALL = 2'h2;
   localparam logic [1:0] ABD_CYC_RET = 2'h3;

   // Decoded instruction handed in by the decoder
   typedef struct packed {
      abd_op_t op;
      logic [7:0] rd;
      logic [7:0] rr;
      logic [7:0] rdh;
      logic [7:0] k;
      logic [11:0] koff;
      logic [15:0] zptr;
      logic [15:0] stack_pc;
      logic next_is_long;
   } abd_instr_t;

   // Results handed back to the register file
   typedef struct packed {
      logic wr_en;
      logic wr_pair;
      logic [7:0] res_lo;
      logic [7:0] res_hi;
      logic push;
      logic [15:0] push_pc;
      logic pop;
   } abd_result_t;
endpackage : abd_pkg
`default_nettype wire

// File: verilog/abd_datapath.sv
// Execution datapath: arithmetic, logic, flags, compare and control flow
//
// Summary of operation
// (RQ1) Add registers, plus carry for carry variant; set ZCNVH; one cycle.
// (RQ2) Word add-immediate on register pair; set ZCNVS; two cycles.
// (RQ3) Word subtract-immediate on register pair; set ZCNVS; two cycles.
// (RQ4) Subtract register or constant from destination; set ZCNVH; one cycle.
// (RQ5) Subtract operand and carry from destination; set ZCNVH; one cycle.
// (RQ6) AND, OR, XOR write result; set only ZNV; one cycle. The code also sets S.
// (RQ7) Set-bits ORs mask; clear-bits ANDs with FF minus mask; ZNV.
// (RQ8) Test ANDs register with itself, sets ZNV, register unchanged.
// (RQ9) Pointer jump loads PC from Z; no flags; two cycles.
// (RQ10) Pointer call pushes return address, loads PC from Z; three cycles.
// (RQ11) Compare-skip equal advances PC by 2 or 3; 1/2/3 cycles.
// (RQ12) Compares subtract without storing; set ZNVCH; one cycle.
// (RQ13) Relative jump/call go to PC plus offset plus one; 2 and 3 cycles.
// (RQ14) Returns pop PC in four cycles; interrupt return sets I flag.
// (RQ15) Complement sets carry; negate sets H; inc/dec set only ZNV. The code also sets S for inc/dec.
`timescale 1ns/1ps
`default_nettype none
module abd_datapath
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Instruction from decoder
   input wire logic instr_valid,
   input wire abd_pkg::abd_instr_t instr,
   // Results
   output var abd_pkg::abd_result_t result,
   output var logic [7:0] sreg,
   output var logic [15:0] pc,
   output var logic busy
);
   // --------------------------------------------------------------
   // Byte arithmetic
   // --------------------------------------------------------------
   abd_pkg::abd_op_t op;
   logic [7:0] a;
   logic [7:0] b;
   logic cin;
   logic do_sub;
   logic [8:0] sum9;
   logic [4:0] sum5;
   logic [7:0] r8;
   logic c8;
   logic h8;
   logic v8;
   logic [15:0] w_in;
   logic [16:0] w_res;
   logic [7:0] next_sreg;
   logic take;

   assign op = instr.op;
   assign take = instr_valid && !busy;
   assign w_in = {instr.rdh, instr.rd};

   always_comb
   begin
      a = instr.rd;
      b = instr.rr;
      cin = 1'b0;
      do_sub = 1'b0;
      case (op)
         abd_pkg::ABD_ADC: cin = sreg[abd_pkg::ABD_FC];         // RQ1
         abd_pkg::ABD_SUB, abd_pkg::ABD_CMP: do_sub = 1'b1;      // RQ4 RQ12
         abd_pkg::ABD_SUB_BORROW, abd_pkg::ABD_CMP_BORROW:       // RQ5 RQ12
         begin
            do_sub = 1'b1;
            cin = sreg[abd_pkg::ABD_FC];
         end
         abd_pkg::ABD_TWOS_CPL:                                // RQ15
         begin
            a = abd_pkg::ABD_ZERO8;
            b = instr.rd;
            do_sub = 1'b1;
         end
         default: ;
      endcase
      if (do_sub)
      begin
         sum9 = {1'b0, a} - {1'b0, b} - {8'h00, cin};
         sum5 = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
         v8 = (a[7] & ~b[7] & ~sum9[7]) | (~a[7] & b[7] & sum9[7]);
      end
      else
      begin
         sum9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
         sum5 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
         v8 = (a[7] & b[7] & ~sum9[7]) | (~a[7] & ~b[7] & sum9[7]);
      end
      c8 = sum9[8];
      h8 = sum5[4];
   end

   // --------------------------------------------------------------
   // Result and flag selection
   // --------------------------------------------------------------
   always_comb
   begin
      r8 = sum9[7:0];
      w_res = {1'b0, w_in} + {9'h000, instr.k};
      next_sreg = sreg;
      case (op)
         abd_pkg::ABD_ADD, abd_pkg::ABD_ADC, abd_pkg::ABD_SUB, abd_pkg::ABD_SUB_BORROW,
         abd_pkg::ABD_CMP, abd_pkg::ABD_TWOS_CPL:             // RQ1 RQ4 RQ5 RQ12 RQ15
         begin
            next_sreg[abd_pkg::ABD_FC] = c8;
            next_sreg[abd_pkg::ABD_FH] = h8;
            next_sreg[abd_pkg::ABD_FV] = v8;
         end
         // Carry-variant compare keeps Z only if it was set: chains across bytes
         abd_pkg::ABD_CMP_BORROW:                             // RQ12
         begin
            next_sreg[abd_pkg::ABD_FC] = c8;
            next_sreg[abd_pkg::ABD_FH] = h8;
            next_sreg[abd_pkg::ABD_FV] = v8;
         end
         abd_pkg::ABD_WADD, abd_pkg::ABD_WSUB:                 // RQ2 RQ3
         begin
            if (op == abd_pkg::ABD_WSUB)
               w_res = {1'b0, w_in} - {9'h000, instr.k};
            next_sreg[abd_pkg::ABD_FC] = w_res[16];
            next_sreg[abd_pkg::ABD_FV] = (op == abd_pkg::ABD_WADD) ?
               (~w_in[15] & w_res[15]) : (w_in[15] & ~w_res[15]);
         end
         abd_pkg::ABD_AND, abd_pkg::ABD_ZS_TEST: r8 = instr.rd & instr.rr;   // RQ6 RQ8
         abd_pkg::ABD_OR: r8 = instr.rd | instr.rr;                     // RQ6
         abd_pkg::ABD_XOR: r8 = instr.rd ^ instr.rr;                    // RQ6
         abd_pkg::ABD_SET_BITS: r8 = instr.rd | instr.k;                // RQ7
         abd_pkg::ABD_CLEAR_BITS: r8 = instr.rd & (abd_pkg::ABD_ALL_ONES - instr.k); // RQ7
         abd_pkg::ABD_COM:                                             // RQ15
         begin
            r8 = abd_pkg::ABD_ALL_ONES - instr.rd;
            next_sreg[abd_pkg::ABD_FC] = 1'b1;
         end
         abd_pkg::ABD_INC: r8 = instr.rd + 8'h01;                       // RQ15
         abd_pkg::ABD_DEC: r8 = instr.rd - 8'h01;                       // RQ15
         abd_pkg::ABD_ZERO_REG: r8 = abd_pkg::ABD_ZERO8;
         abd_pkg::ABD_ONES_REG: r8 = abd_pkg::ABD_ALL_ONES;
         abd_pkg::ABD_INT_EXIT: next_sreg[abd_pkg::ABD_FI] = 1'b1;     // RQ14
         default: ;
      endcase
      case (op)
         abd_pkg::ABD_AND, abd_pkg::ABD_ZS_TEST, abd_pkg::ABD_OR, abd_pkg::ABD_XOR,
         abd_pkg::ABD_SET_BITS, abd_pkg::ABD_CLEAR_BITS, abd_pkg::ABD_COM, abd_pkg::ABD_ZERO_REG:
            next_sreg[abd_pkg::ABD_FV] = 1'b0;                          // RQ6 RQ7 RQ8
         abd_pkg::ABD_INC:
            next_sreg[abd_pkg::ABD_FV] = (instr.rd == 8'h7F);           // RQ15
         abd_pkg::ABD_DEC:
            next_sreg[abd_pkg::ABD_FV] = (instr.rd == 8'h80);           // RQ15
         default: ;
      endcase
      case (op)
         abd_pkg::ABD_WADD, abd_pkg::ABD_WSUB:
         begin
            next_sreg[abd_pkg::ABD_FZ] = (w_res[15:0] == 16'h0000);
            next_sreg[abd_pkg::ABD_FN] = w_res[15];
            next_sreg[abd_pkg::ABD_FS] = w_res[15] ^ next_sreg[abd_pkg::ABD_FV];
         end
         abd_pkg::ABD_CMP_BORROW, abd_pkg::ABD_SUB_BORROW:                 // RQ5 RQ12
         begin
            next_sreg[abd_pkg::ABD_FZ] = (r8 == abd_pkg::ABD_ZERO8) & sreg[abd_pkg::ABD_FZ];
            next_sreg[abd_pkg::ABD_FN] = r8[7];
            next_sreg[abd_pkg::ABD_FS] = r8[7] ^ next_sreg[abd_pkg::ABD_FV];
         end
         abd_pkg::ABD_ADD, abd_pkg::ABD_ADC, abd_pkg::ABD_SUB, abd_pkg::ABD_CMP,
         abd_pkg::ABD_TWOS_CPL, abd_pkg::ABD_AND, abd_pkg::ABD_ZS_TEST, abd_pkg::ABD_OR,
         abd_pkg::ABD_XOR, abd_pkg::ABD_SET_BITS, abd_pkg::ABD_CLEAR_BITS, abd_pkg::ABD_COM,
         abd_pkg::ABD_INC, abd_pkg::ABD_DEC, abd_pkg::ABD_ZERO_REG:
         begin
            next_sreg[abd_pkg::ABD_FZ] = (r8 == abd_pkg::ABD_ZERO8);
            next_sreg[abd_pkg::ABD_FN] = r8[7];
            next_sreg[abd_pkg::ABD_FS] = r8[7] ^ next_sreg[abd_pkg::ABD_FV];
         end
         default: ;
      endcase
   end

   // --------------------------------------------------------------
   // Status register and write-back
   // --------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         sreg <= abd_pkg::ABD_SREG_RESET;
      else if (take)
         sreg <= next_sreg;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         result <= '0;
      else
      begin
         result.wr_en <= take && !(op inside {abd_pkg::ABD_NOP, abd_pkg::ABD_CMP,
            abd_pkg::ABD_CMP_BORROW, abd_pkg::ABD_CMP_SKIP, abd_pkg::ABD_ZS_TEST, abd_pkg::ABD_REL_JUMP,
            abd_pkg::ABD_PTR_JUMP, abd_pkg::ABD_REL_CALL, abd_pkg::ABD_PTR_CALL,
            abd_pkg::ABD_SUB_EXIT, abd_pkg::ABD_INT_EXIT});        // RQ8 RQ12
         result.wr_pair <= take && (op inside {abd_pkg::ABD_WADD, abd_pkg::ABD_WSUB});
         result.res_lo <= (op inside {abd_pkg::ABD_WADD, abd_pkg::ABD_WSUB}) ? w_res[7:0] : r8;
         result.res_hi <= w_res[15:8];
         result.push <= take && (op inside {abd_pkg::ABD_REL_CALL, abd_pkg::ABD_PTR_CALL}); // RQ10 RQ13
         result.push_pc <= pc + abd_pkg::ABD_ONE16;
         result.pop <= take && (op inside {abd_pkg::ABD_SUB_EXIT, abd_pkg::ABD_INT_EXIT}); // RQ14
      end
   end

   // --------------------------------------------------------------
   // Program counter and cycle count
   // --------------------------------------------------------------
   logic [1:0] wait_cnt;
   logic [15:0] rel_tgt;
   logic skip;

   assign rel_tgt = pc + {{4{instr.koff[11]}}, instr.koff} + abd_pkg::ABD_ONE16;
   assign skip = (op == abd_pkg::ABD_CMP_SKIP) && (instr.rd == instr.rr);

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pc <= abd_pkg::ABD_PC_RESET;
         wait_cnt <= 2'h0;
         busy <= 1'b0;
      end
      else if (busy)
      begin
         wait_cnt <= wait_cnt - 2'h1;
         busy <= (wait_cnt != 2'h1);
      end
      else if (instr_valid)
      begin
         case (op)
            abd_pkg::ABD_REL_JUMP, abd_pkg::ABD_REL_CALL: pc <= rel_tgt;        // RQ13
            abd_pkg::ABD_PTR_JUMP, abd_pkg::ABD_PTR_CALL: pc <= instr.zptr;     // RQ9 RQ10
            abd_pkg::ABD_SUB_EXIT, abd_pkg::ABD_INT_EXIT: pc <= instr.stack_pc; // RQ14
            abd_pkg::ABD_CMP_SKIP:                                              // RQ11
               pc <= pc + (skip ? (instr.next_is_long ? abd_pkg::ABD_SKIP2 : abd_pkg::ABD_SKIP1)
                  : abd_pkg::ABD_ONE16);
            default: pc <= pc + abd_pkg::ABD_ONE16;
         endcase
         case (op)
            abd_pkg::ABD_WADD, abd_pkg::ABD_WSUB: wait_cnt <= abd_pkg::ABD_CYC_WORD; // RQ2 RQ3
            abd_pkg::ABD_REL_JUMP, abd_pkg::ABD_PTR_JUMP: wait_cnt <= abd_pkg::ABD_CYC_JMP;  // RQ9 RQ13
            abd_pkg::ABD_REL_CALL, abd_pkg::ABD_PTR_CALL: wait_cnt <= abd_pkg::ABD_CYC_CALL; // RQ10 RQ13
            abd_pkg::ABD_SUB_EXIT, abd_pkg::ABD_INT_EXIT: wait_cnt <= abd_pkg::ABD_CYC_RET;  // RQ14
            abd_pkg::ABD_CMP_SKIP:                                                         // RQ11
               wait_cnt <= skip ? (instr.next_is_long ? 2'h2 : 2'h1) : 2'h0;
            default: wait_cnt <= 2'h0;
         endcase
         busy <= (op inside {abd_pkg::ABD_WADD, abd_pkg::ABD_WSUB, abd_pkg::ABD_REL_JUMP,
            abd_pkg::ABD_PTR_JUMP, abd_pkg::ABD_REL_CALL, abd_pkg::ABD_PTR_CALL,
            abd_pkg::ABD_SUB_EXIT, abd_pkg::ABD_INT_EXIT}) || skip;
      end
   end

   // --------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------
   property p_add_one;
      @(posedge clk) disable iff (!reset_n)
      take && op == abd_pkg::ABD_ADD |=> !busy && result.wr_en;
   endproperty
   a_add_one: assert property (p_add_one) else $error("add not single cycle"); // RQ1

   property p_word_two;
      @(posedge clk) disable iff (!reset_n)
      take && op == abd_pkg::ABD_WADD |=> busy ##1 !busy;
   endproperty
   a_word_two: assert property (p_word_two) else $error("word add not two cycles"); // RQ2

   property p_wsub_two;
      @(posedge clk) disable iff (!reset_n)
      take && op == abd_pkg::ABD_WSUB |=> result.wr_pair ##1 !busy;
   endproperty
   a_wsub_two: assert property (p_wsub_two) else $error("word sub not two cycles"); // RQ3

   property p_logic_keep_c;
      @(posedge clk) disable iff (!reset_n)
      take && op inside {abd_pkg::ABD_AND, abd_pkg::ABD_OR, abd_pkg::ABD_XOR}
      |=> sreg[abd_pkg::ABD_FC] == $past(sreg[abd_pkg::ABD_FC]) && !sreg[abd_pkg::ABD_FV];
   endproperty
   a_logic_keep_c: assert property (p_logic_keep_c) else $error("logic op touched carry"); // RQ6

   property p_pointer_jump;
      @(posedge clk) disable iff (!reset_n)
      take && op == abd_pkg::ABD_PTR_JUMP |=> pc == $past(instr.zptr) && sreg == $past(sreg) ##1 !busy;
   endproperty
   a_pointer_jump: assert property (p_pointer_jump) else $error("pointer jump wrong"); // RQ9

   property p_pointer_call;
      @(posedge clk) disable iff (!reset_n)
      take && op == abd_pkg::ABD_PTR_CALL |=> result.push ##1 busy ##1 !busy;
   endproperty
   a_pointer_call: assert property (p_pointer_call) else $error("pointer call not three cycles"); // RQ10

   property p_cp_nowrite;
      @(posedge clk) disable iff (!reset_n)
      take && op == abd_pkg::ABD_CMP |=> !result.wr_en && !busy;
   endproperty
   a_cp_nowrite: assert property (p_cp_nowrite) else $error("compare stored result"); // RQ12

   property p_interrupt_exit;
      @(posedge clk) disable iff (!reset_n)
      take && op == abd_pkg::ABD_INT_EXIT |=> sreg[abd_pkg::ABD_FI] && result.pop ##3 !busy;
   endproperty
   a_interrupt_exit: assert property (p_interrupt_exit) else $error("interrupt return wrong"); // RQ14
endmodule // abd_datapath
`default_nettype wire

// File: verification/test_alu_branch_datapath.sv
// Self-checking testbench for the ALU and branch datapath
`timescale 1ns/1ps
`default_nettype none
module test_alu_branch_datapath;
   // ------------------------------------------------------------
   // Signals and design instance
   // ------------------------------------------------------------
   typedef struct {
      abd_pkg::abd_op_t op;
      logic [7:0] rd;
      logic [7:0] src;
      logic [7:0] res;
      logic [7:0] flg;
      logic wr;
   } abd_case_t;

   logic clk;
   logic reset_n;
   logic instr_valid;
   abd_pkg::abd_instr_t instr;
   abd_pkg::abd_result_t result;
   logic [7:0] sreg;
   logic [15:0] pc;
   logic busy;
   int error_cnt;
   int cmp_count;
   int cyc;
   logic [15:0] epc;

   // Rows run in order: most expected flag bytes depend on the carry, half carry or zero left by the row above
   abd_case_t tbl [23] = '{
      '{abd_pkg::ABD_ADD, 8'h0F, 8'h01, 8'h10, 8'h20, 1'b1}, '{abd_pkg::ABD_ADD, 8'hFF, 8'h01, 8'h00, 8'h23, 1'b1},
      '{abd_pkg::ABD_ADC, 8'h7F, 8'h00, 8'h80, 8'h2C, 1'b1}, '{abd_pkg::ABD_SUB, 8'h10, 8'h01, 8'h0F, 8'h20, 1'b1},
      '{abd_pkg::ABD_SUB, 8'h00, 8'h01, 8'hFF, 8'h35, 1'b1}, '{abd_pkg::ABD_SUB_BORROW, 8'h05, 8'h05, 8'hFF, 8'h35, 1'b1},
      '{abd_pkg::ABD_AND, 8'hF0, 8'h8F, 8'h80, 8'h35, 1'b1}, '{abd_pkg::ABD_OR, 8'h00, 8'h00, 8'h00, 8'h23, 1'b1},
      '{abd_pkg::ABD_XOR, 8'hFF, 8'h0F, 8'hF0, 8'h35, 1'b1}, '{abd_pkg::ABD_SET_BITS, 8'h01, 8'h80, 8'h81, 8'h35, 1'b1},
      '{abd_pkg::ABD_CLEAR_BITS, 8'h81, 8'h81, 8'h00, 8'h23, 1'b1},
      '{abd_pkg::ABD_ZS_TEST, 8'h80, 8'h80, 8'h80, 8'h35, 1'b0},
      '{abd_pkg::ABD_SUB_BORROW, 8'h01, 8'h00, 8'h00, 8'h00, 1'b1}, '{abd_pkg::ABD_COM, 8'h55, 8'h00, 8'hAA, 8'h15, 1'b1},
      '{abd_pkg::ABD_TWOS_CPL, 8'h01, 8'h00, 8'hFF, 8'h35, 1'b1}, '{abd_pkg::ABD_ZERO_REG, 8'h5A, 8'h00, 8'h00, 8'h23, 1'b1},
      '{abd_pkg::ABD_ONES_REG, 8'h12, 8'h00, 8'hFF, 8'h23, 1'b1}, '{abd_pkg::ABD_INC, 8'h7F, 8'h00, 8'h80, 8'h2D, 1'b1},
      '{abd_pkg::ABD_DEC, 8'h80, 8'h00, 8'h7F, 8'h39, 1'b1}, '{abd_pkg::ABD_CMP, 8'h05, 8'h05, 8'h00, 8'h02, 1'b0},
      '{abd_pkg::ABD_CMP_BORROW, 8'h05, 8'h05, 8'h00, 8'h02, 1'b0}, '{abd_pkg::ABD_CMP, 8'h80, 8'h01, 8'h00, 8'h38, 1'b0},
      '{abd_pkg::ABD_CMP_BORROW, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0}};

   abd_datapath abd_datapath_inst (.clk(clk), .reset_n(reset_n), .instr_valid(instr_valid), .instr(instr),
      .result(result), .sreg(sreg), .pc(pc), .busy(busy));

   always #2 clk = ~clk;

   // ------------------------------------------------------------
   // Reporting
   // ------------------------------------------------------------
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // A hang in a busy wait must still end in the closing report
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         error_cnt++;
         close_out();
      end
   end

   // ------------------------------------------------------------
   // Drivers: called at a falling edge; go returns at the next one, fin after the busy cycles plus one idle cycle
   // ------------------------------------------------------------
   task automatic go(abd_pkg::abd_op_t op, logic [7:0] rd, logic [7:0] src, logic [7:0] rdh, logic [11:0] off,
                     logic [15:0] z, logic [15:0] stk, logic lng);
      instr = '{op, rd, src, rdh, src, off, z, stk, lng};
      instr_valid = 1'b1;
      @(negedge clk);
   endtask

   // Drops the request, counts busy cycles, then idles one cycle so valid never toggles twice in a step
   task automatic fin(int extra);
      int n;
      n = 0;
      instr_valid = 1'b0;
      while (busy === 1'b1 && n < 8)
      begin
         @(negedge clk);
         n++;
      end
      check("busy cycles", 16'(n), 16'(extra));
      @(negedge clk);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_byte_ops();
      foreach (tbl[i])
      begin
         go(tbl[i].op, tbl[i].rd, tbl[i].src, 8'h00, 12'h000, 16'h0000, 16'h0000, 1'b0);
         epc = epc + 16'h0001;
         if (tbl[i].wr !== 1'bx)
         begin
            check("write enable", 16'(result.wr_en), 16'(tbl[i].wr));
            if (tbl[i].wr === 1'b1)
               check("result", 16'(result.res_lo), 16'(tbl[i].res));
         end
         check("flags", 16'(sreg), 16'(tbl[i].flg));
         check("pc", pc, epc);
      end
   endtask

   // Optionally offers a second op while busy; it must be ignored
   task automatic t_word(abd_pkg::abd_op_t op, logic [15:0] pair, logic [7:0] k, logic [15:0] res,
                         logic [7:0] flg, logic refuse);
      go(op, pair[7:0], k, pair[15:8], 12'h000, 16'h0000, 16'h0000, 1'b0);
      check("pair write", 16'(result.wr_pair), 16'h0001);
      check("pair result", {result.res_hi, result.res_lo}, res);
      if (refuse === 1'b1)
      begin
         go(abd_pkg::ABD_ONES_REG, 8'h3C, 8'h00, 8'h00, 12'h000, 16'h0000, 16'h0000, 1'b0);
         check("ignored write", 16'(result.wr_en), 16'h0000);
         fin(0);
      end
      else
         fin(1);
      epc = epc + 16'h0001;
      check("pc", pc, epc);
      check("flags", 16'(sreg), 16'(flg));
   endtask

   task automatic t_flow(abd_pkg::abd_op_t op, logic [7:0] a, logic [7:0] b, logic [11:0] off, logic [15:0] z,
                         logic [15:0] stk, logic lng, logic [15:0] npc, int extra, logic psh, logic [7:0] flg);
      go(op, a, b, 8'h00, off, z, stk, lng);
      check("push", 16'(result.push), 16'(psh));
      if (psh === 1'b1)
         check("return address", result.push_pc, epc + 16'h0001);
      check("pop", 16'(result.pop), 16'(op == abd_pkg::ABD_SUB_EXIT || op == abd_pkg::ABD_INT_EXIT));
      fin(extra);
      epc = npc;
      check("pc", pc, epc);
      check("flags", 16'(sreg), 16'(flg));
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      reset_n = 1'b0;
      instr_valid = 1'b0;
      instr = '0;
      error_cnt = 0;
      cmp_count = 0;
      cyc = 0;
      epc = abd_pkg::ABD_PC_RESET;
      repeat (12) @(negedge clk);
      check("reset flags", 16'(sreg), 16'(abd_pkg::ABD_SREG_RESET));
      check("reset pc", pc, abd_pkg::ABD_PC_RESET);
      check("reset busy", 16'(busy), 16'h0000);
      reset_n = 1'b1;
      t_byte_ops();
      t_word(abd_pkg::ABD_WADD, 16'h00FF, 8'h01, 16'h0100, 8'h00, 1'b0);
      t_word(abd_pkg::ABD_WSUB, 16'h0000, 8'h01, 16'hFFFF, 8'h15, 1'b1);
      t_word(abd_pkg::ABD_WADD, 16'hFFFF, 8'h01, 16'h0000, 8'h03, 1'b0);
      t_word(abd_pkg::ABD_WSUB, 16'h8000, 8'h01, 16'h7FFF, 8'h18, 1'b0);
      t_flow(abd_pkg::ABD_REL_JUMP, 8'h00, 8'h00, 12'h010, 16'h0000, 16'h0000, 1'b0, epc + 16'h0011, 1, 1'b0, 8'h18);
      t_flow(abd_pkg::ABD_REL_JUMP, 8'h00, 8'h00, 12'hFFE, 16'h0000, 16'h0000, 1'b0, epc + 16'hFFFF, 1, 1'b0, 8'h18);
      t_flow(abd_pkg::ABD_PTR_JUMP, 8'h00, 8'h00, 12'h000, 16'h1234, 16'h0000, 1'b0, 16'h1234, 1, 1'b0, 8'h18);
      t_flow(abd_pkg::ABD_REL_CALL, 8'h00, 8'h00, 12'h005, 16'h0000, 16'h0000, 1'b0, epc + 16'h0006, 2, 1'b1, 8'h18);
      t_flow(abd_pkg::ABD_PTR_CALL, 8'h00, 8'h00, 12'h000, 16'h2000, 16'h0000, 1'b0, 16'h2000, 2, 1'b1, 8'h18);
      t_flow(abd_pkg::ABD_CMP_SKIP, 8'h5A, 8'h5A, 12'h000, 16'h0000, 16'h0000, 1'b0, epc + 16'h0002, 1, 1'b0, 8'h18);
      t_flow(abd_pkg::ABD_CMP_SKIP, 8'h5A, 8'h5A, 12'h000, 16'h0000, 16'h0000, 1'b1, epc + 16'h0003, 2, 1'b0, 8'h18);
      t_flow(abd_pkg::ABD_CMP_SKIP, 8'h5A, 8'h5B, 12'h000, 16'h0000, 16'h0000, 1'b1, epc + 16'h0001, 0, 1'b0, 8'h18);
      t_flow(abd_pkg::ABD_SUB_EXIT, 8'h00, 8'h00, 12'h000, 16'h0000, 16'h0ABC, 1'b0, 16'h0ABC, 3, 1'b0, 8'h18);
      t_flow(abd_pkg::ABD_INT_EXIT, 8'h00, 8'h00, 12'h000, 16'h0000, 16'h0100, 1'b0, 16'h0100, 3, 1'b0, 8'h98);
      close_out();
   end
endmodule // test_alu_branch_datapath
`default_nettype wire
